// ---- design/lbe_error_report.sv ----
`timescale 1ns/1ns
`include "lbe_defines.svh"

//Behaviour
// RULE_01 - status is write-one-to-clear; writes never set; reads show status
// RULE_02 - after a report, status holds until capture-valid is cleared
// RULE_03 - bit 0 set when no beat acknowledged within count times prescale
// RULE_04 - bit 1 set when a command wait times out against its limit
// RULE_05 - bit 2 set on uncorrectable ECC; block and bank recorded
// RULE_06 - bit 5 set on read-only write; monitor time-out usually follows
// RULE_07 - bit 12 set when a transaction hits no bank
// RULE_08 - bit 31 set when a NAND operation completes
// RULE_09 - check-off bits 0,1,2,5,12,31 stop detection, apart from enables
// RULE_10 - monitor check off still lets the bus time out, nothing recorded
// RULE_11 - command check off still ends the wait, nothing recorded
// RULE_12 - enables gate status onto the interrupt; clearing status drops it
// RULE_13 - software clears pending status before setting interrupt enables
// RULE_14 - attribute bit 3 records direction: 0 write, 1 read
// RULE_15 - attribute bits 11-15 capture initiator code when supplied
// RULE_16 - bits 16-19 flag failing 512-byte block; small page keeps 17-19 zero
// RULE_17 - bits 20-23 flag the bank that had the error
// RULE_18 - while valid is set, status, attributes and address hold
// RULE_19 - address register holds the full 32-bit transaction address
// RULE_20 - captures during NAND special operations may be inaccurate
// RULE_21 - monitor period: count times power-of-two prescale; zero is maximum
// RULE_22 - interrupt is a level: OR of enabled status bits
// RULE_23 - event with valid clear sets status, captures, sets valid together
module lbe_error_report
  import lbe_pkg::*;
#(
  parameter int TW = 27
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // transaction monitor
  input  wire logic        txn_start,
  input  wire logic        txn_ack,
  input  wire logic        txn_write,
  input  wire logic [31:0] txn_addr,
  input  wire logic        txn_src_valid,
  input  wire logic [4:0]  txn_src,
  input  wire logic [1:0]  txn_bank,
  input  wire logic        readonly_hit,
  input  wire logic        bank_miss,
  // nand machine
  input  wire logic        nand_wait_start,
  input  wire logic        nand_ready,
  input  wire logic        ecc_fail,
  input  wire logic [1:0]  ecc_block,
  input  wire logic        large_page,
  input  wire logic        nand_op_done,
  // results
  output logic             monitor_timeout,
  output logic             cmd_wait_timeout,
  output logic             irq
);

  lbe_word_t status_r;
  lbe_word_t check_off_r;
  lbe_word_t irq_en_r;
  lbe_word_t attr_r;
  lbe_word_t addr_r;
  lbe_word_t config_r;
  lbe_word_t prdata_r;
  logic      pready_r;
  logic      pslverr_r;
  logic      irq_r;

  // apb decode
  wire setup    = psel && !penable && !pready_r;
  wire wr_done  = psel && penable && pready_r && pwrite;
  wire hit_stat = paddr == `LBE_OFS_STATUS;
  wire hit_off  = paddr == `LBE_OFS_CHECK_OFF;
  wire hit_ien  = paddr == `LBE_OFS_IRQ_ENABLE;
  wire hit_attr = paddr == `LBE_OFS_ATTR;
  wire hit_addr = paddr == `LBE_OFS_ADDR;
  wire hit_cfg  = paddr == `LBE_OFS_CONFIG;
  wire mapped   = hit_stat | hit_off | hit_ien | hit_attr | hit_addr | hit_cfg;
  wire wr_stat  = wr_done && hit_stat;
  wire wr_off   = wr_done && hit_off;
  wire wr_ien   = wr_done && hit_ien;
  wire wr_attr  = wr_done && hit_attr;
  wire wr_cfg   = wr_done && hit_cfg;

  lbe_word_t rd_mux;
  assign rd_mux = hit_stat ? status_r :
                  hit_off  ? check_off_r :
                  hit_ien  ? irq_en_r :
                  hit_attr ? attr_r :
                  hit_addr ? addr_r :
                  hit_cfg  ? config_r : `LBE_RST_WORD;

  // monitor period from configuration
  wire [7:0] cfg_count = config_r[`LBE_CF_COUNT_HI:`LBE_CF_COUNT_LO];
  wire [3:0] cfg_scale = config_r[`LBE_CF_SCALE_HI:`LBE_CF_SCALE_LO];
  wire [3:0] cfg_cwl   = config_r[`LBE_CF_CWL_HI:`LBE_CF_CWL_LO];
  wire [8:0] mon_count = (cfg_count == 8'h00) ? `LBE_MON_ZERO_COUNT :
                         {1'b0, cfg_count}; // [RULE_21]
  lbe_shift_t mon_shift;
  assign mon_shift = `LBE_MON_SHIFT_BASE + {1'b0, cfg_scale}; // [RULE_21]
  wire [TW-1:0] mon_limit = {{(TW-9){1'b0}}, mon_count} << mon_shift;
  wire [TW-1:0] cmd_limit = {{(TW-9){1'b0}}, `LBE_CMD_BASE_COUNT}
                            << cfg_cwl;

  wire mon_expire;
  wire cmd_expire;

  // the bus time-out fires whatever the check-off says
  lbe_timeout_timer #(.TW(TW)) u_mon_timer ( // [RULE_03] [RULE_10]
    .pclk    (pclk),
    .presetn (presetn),
    .start   (txn_start),
    .stop    (txn_ack),
    .limit   (mon_limit),
    .expire  (mon_expire)
  );

  // the command wait ends on time-out even with its check off
  lbe_timeout_timer #(.TW(TW)) u_cmd_timer ( // [RULE_04] [RULE_11]
    .pclk    (pclk),
    .presetn (presetn),
    .start   (nand_wait_start),
    .stop    (nand_ready),
    .limit   (cmd_limit),
    .expire  (cmd_expire)
  );

  // raw events at their status positions
  lbe_word_t ev_raw;
  assign ev_raw = {nand_op_done, 18'h0, bank_miss, 6'h0, readonly_hit,
                   2'h0, ecc_fail, cmd_expire, mon_expire};
  // [RULE_03] [RULE_04] [RULE_05] [RULE_06] [RULE_07] [RULE_08]

  // detection gated only by check-off, never by irq enables
  lbe_word_t ev_live;
  assign ev_live = ev_raw & ~check_off_r & `LBE_EV_MASK; // [RULE_09]

  // clearing valid in the same cycle as an event lets the event in
  wire clr_valid = wr_attr && !pwdata[`LBE_AT_VALID];
  wire cap_en    = (ev_live != 32'h0) &&
                   (!attr_r[`LBE_AT_VALID] || clr_valid); // [RULE_02] [RULE_18]

  // attribute capture
  lbe_bank_mask_t bank_mask;
  lbe_bank_mask_t pb_mask;
  wire [1:0] blk = large_page ? ecc_block : 2'h0; // [RULE_16]
  assign bank_mask = 4'h1 << txn_bank; // [RULE_17]
  assign pb_mask   = ev_live[`LBE_EV_ECC] ? (4'h1 << blk) : 4'h0; // [RULE_16]
  wire [4:0] src_cap = txn_src_valid ? txn_src : 5'h00; // [RULE_15]

  lbe_word_t attr_cap;
  assign attr_cap = {1'b1, 7'h0, bank_mask, pb_mask, src_cap, 7'h0,
                     !txn_write, 3'h0}; // [RULE_14] [RULE_23]

  lbe_word_t status_nxt;
  lbe_word_t attr_nxt;
  lbe_word_t addr_nxt;
  assign status_nxt = (status_r & ~(wr_stat ? pwdata : 32'h0)) |
                      (cap_en ? ev_live : 32'h0); // [RULE_01] [RULE_23]
  assign attr_nxt = cap_en    ? attr_cap :
                    clr_valid ? {1'b0, attr_r[30:0]} : attr_r; // [RULE_18]
  // captured as-is even during special nand operations
  assign addr_nxt = cap_en ? txn_addr : addr_r; // [RULE_19] [RULE_20]

  wire irq_nxt = |(status_r & irq_en_r); // [RULE_12] [RULE_22]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= `LBE_RST_WORD;
      attr_r   <= `LBE_RST_WORD;
      addr_r   <= `LBE_RST_WORD;
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      attr_r   <= attr_nxt;
      addr_r   <= addr_nxt;
      irq_r    <= irq_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_off_r <= `LBE_RST_WORD;
      irq_en_r    <= `LBE_RST_WORD;
      config_r    <= `LBE_RST_WORD;
    end else begin
      if (wr_off) begin
        check_off_r <= pwdata & `LBE_EV_MASK; // [RULE_09]
      end
      if (wr_ien) begin
        irq_en_r <= pwdata & `LBE_EV_MASK;
      end
      if (wr_cfg) begin
        config_r <= pwdata & `LBE_CF_MASK;
      end
    end
  end

  // no wait states: pready rises in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= `LBE_RST_WORD;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      prdata_r  <= setup ? rd_mux : `LBE_RST_WORD;
    end
  end

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign irq              = irq_r;
  assign monitor_timeout  = mon_expire;
  assign cmd_wait_timeout = cmd_expire;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_w1c_clears: assert property ( // [RULE_01]
    (wr_stat && !cap_en) |=> ((status_r & $past(pwdata)) == 32'h0))
    else $error("status bit survived a write of one");

  chk_w1c_no_set: assert property ( // [RULE_01]
    (wr_stat && !cap_en) |=> ((status_r & ~$past(status_r)) == 32'h0))
    else $error("status write set a bit");

  chk_hold_valid: assert property ( // [RULE_18]
    (attr_r[`LBE_AT_VALID] && !clr_valid)
      |=> ($stable(addr_r) && $stable(attr_r) &&
           ((status_r & ~$past(status_r)) == 32'h0)))
    else $error("captured state changed while valid");

  chk_monitor_flag: assert property ( // [RULE_03]
    (mon_expire && !check_off_r[0] && !attr_r[`LBE_AT_VALID])
      |=> (status_r[0] && attr_r[`LBE_AT_VALID]))
    else $error("monitor time-out not recorded");

  chk_monitor_off: assert property ( // [RULE_10]
    (check_off_r[0] && !status_r[0] && mon_expire) |=> !status_r[0])
    else $error("disabled monitor check recorded");

  chk_cmd_end_off: assert property ( // [RULE_11]
    (u_cmd_timer.run_r && check_off_r[1] && !nand_ready && !wr_off &&
     !nand_wait_start && (u_cmd_timer.cnt_r >= cmd_limit))
      |=> (cmd_wait_timeout && !ev_live[1]))
    else $error("command wait not ended by timer");

  chk_irq_level: assert property ( // [RULE_22]
    ##1 (irq == $past(|(status_r & irq_en_r))))
    else $error("interrupt level mismatch");

  chk_irq_clear: assert property ( // [RULE_12]
    (irq && wr_stat && !cap_en &&
     ((status_r & irq_en_r & ~pwdata) == 32'h0))
      |=> ##1 !irq)
    else $error("interrupt not negated after clearing");

  chk_capture_dir: assert property ( // [RULE_14]
    cap_en |=> (attr_r[`LBE_AT_DIR] == !$past(txn_write)) &&
               (addr_r == $past(txn_addr)))
    else $error("direction or address not captured");

  chk_bank_flag: assert property ( // [RULE_17]
    cap_en |=> (attr_r[`LBE_AT_BANK_HI:`LBE_AT_BANK_LO] ==
                (4'h1 << $past(txn_bank))))
    else $error("bank flag not captured");

  chk_small_page: assert property ( // [RULE_16]
    (cap_en && ev_live[`LBE_EV_ECC] && !large_page)
      |=> (attr_r[`LBE_AT_PB_HI:`LBE_AT_PB_LO] == 4'h1))
    else $error("small page block flags wrong");

  chk_apb_answer: assert property (
    setup |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

endmodule // lbe_error_report

// ---- include/lbe_defines.svh ----
`ifndef LBE_DEFINES_SVH
`define LBE_DEFINES_SVH

// register byte offsets
`define LBE_OFS_STATUS      8'h00
`define LBE_OFS_CHECK_OFF   8'h04
`define LBE_OFS_IRQ_ENABLE  8'h08
`define LBE_OFS_ATTR        8'h0C
`define LBE_OFS_ADDR        8'h10
`define LBE_OFS_CONFIG      8'h14

// event bit positions, shared by status, check-off and irq enable
`define LBE_EV_MONITOR      0
`define LBE_EV_NAND_TO      1
`define LBE_EV_ECC          2
`define LBE_EV_READONLY     5
`define LBE_EV_BANK_MISS    12
`define LBE_EV_DONE         31
`define LBE_EV_MASK         32'h8000_1027

// attribute fields
`define LBE_AT_DIR          3
`define LBE_AT_SRC_LO       11
`define LBE_AT_SRC_HI       15
`define LBE_AT_PB_LO        16
`define LBE_AT_PB_HI        19
`define LBE_AT_BANK_LO      20
`define LBE_AT_BANK_HI      23
`define LBE_AT_VALID        31

// config fields
`define LBE_CF_SCALE_LO     0
`define LBE_CF_SCALE_HI     3
`define LBE_CF_COUNT_LO     8
`define LBE_CF_COUNT_HI     15
`define LBE_CF_CWL_LO       16
`define LBE_CF_CWL_HI       19
`define LBE_CF_MASK         32'h000F_FF0F

// reset values
`define LBE_RST_WORD        32'h0000_0000

// timing counts
`define LBE_MON_ZERO_COUNT  9'h100
`define LBE_MON_SHIFT_BASE  5'h03
`define LBE_CMD_BASE_COUNT  9'h100

`endif

// ---- include/lbe_pkg.sv ----
package lbe_pkg;

  typedef logic [31:0] lbe_word_t;
  typedef logic [3:0]  lbe_bank_mask_t;
  typedef logic [4:0]  lbe_shift_t;

endpackage

// ---- design/lbe_timeout_timer.sv ----
`timescale 1ns/1ns
`include "lbe_defines.svh"

module lbe_timeout_timer
  import lbe_pkg::*;
#(
  parameter int TW = 27
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // control
  input  wire logic          start,
  input  wire logic          stop,
  input  wire logic [TW-1:0] limit,
  // result
  output logic               expire
);

  logic [TW-1:0] cnt_r;
  logic          run_r;
  logic          expire_r;
  wire           hit = run_r && !start && !stop && (cnt_r >= limit);

  // a new start restarts the count, so a stale wait never fires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (start) begin
      cnt_r <= TW'(1);
      run_r <= 1'b1;
    end else if (stop || hit) begin
      run_r <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_r + TW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expire_r <= 1'b0;
    end else begin
      expire_r <= hit;
    end
  end

  assign expire = expire_r;

endmodule // lbe_timeout_timer

// ---- verification/lbe_error_report_tb.sv ----
`timescale 1ns/1ns
`include "lbe_defines.svh"

module lbe_error_report_tb
  import lbe_pkg::*;
;
  logic       pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic       pwrite = 1'h0, e;
  logic [7:0] paddr = 8'h00;
  lbe_word_t  pwdata = 32'h0, txn_addr = 32'hA5C3_1E70, prdata, q;
  logic       pready, pslverr, monitor_timeout, cmd_wait_timeout, irq;
  logic       txn_start = 1'h0, txn_ack = 1'h0, txn_write = 1'h0;
  logic       txn_src_valid = 1'h1, readonly_hit = 1'h0, bank_miss = 1'h0;
  logic [4:0] txn_src = 5'h15;
  logic [1:0] txn_bank = 2'h2, ecc_block = 2'h1;
  logic       nand_wait_start = 1'h0, nand_ready = 1'h0, ecc_fail = 1'h0;
  logic       large_page = 1'h1, nand_op_done = 1'h0;
  int         n_mismatch = 0, n_compared = 0;

  lbe_error_report uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .txn_start, .txn_ack, .txn_write, .txn_addr,
    .txn_src_valid, .txn_src, .txn_bank, .readonly_hit, .bank_miss,
    .nand_wait_start, .nand_ready, .ecc_fail, .ecc_block, .large_page,
    .nand_op_done, .monitor_timeout, .cmd_wait_timeout, .irq
  );

  always #5 pclk = ~pclk;

  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp(input string s, input lbe_word_t x, input lbe_word_t g);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", s, x, g);
    end
  endtask

  // pready and read data are taken at the rising edge that ends the access
  task automatic apb(input logic w, input logic [7:0] a, input lbe_word_t d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    cmp("pready", 32'h1, pready);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input lbe_word_t x);
    apb(1'h0, a, 32'h0);
    cmp($sformatf("register %h", a), x, q);
  endtask

  task automatic wr(input logic [7:0] a, input lbe_word_t d);
    apb(1'h1, a, d);
  endtask

  task automatic ev(input int k);
    @(posedge pclk);
    case (k)
      0: readonly_hit <= 1'h1;
      1: bank_miss <= 1'h1;
      2: ecc_fail <= 1'h1;
      3: nand_op_done <= 1'h1;
      4: txn_start <= 1'h1;
      5: nand_wait_start <= 1'h1;
      6: txn_ack <= 1'h1;
      default: nand_ready <= 1'h1;
    endcase
    @(posedge pclk);
    {readonly_hit, bank_miss, ecc_fail, nand_op_done} <= 4'h0;
    {txn_start, nand_wait_start, txn_ack, nand_ready} <= 4'h0;
  endtask

  task automatic clr;
    wr(`LBE_OFS_STATUS, 32'hFFFF_FFFF);
    wr(`LBE_OFS_ATTR, 32'h0);
  endtask

  task automatic tmo(input int k, input int lo, input int hi);
    int n;
    n = 0;
    ev(k);
    do begin
      @(negedge pclk);
      n++;
    end while ((k == 4 ? monitor_timeout : cmd_wait_timeout) !== 1'b1
               && n < hi + 4);
    cmp("timeout cycles in range", 32'h1, n >= lo && n <= hi);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
    apb(1'h0, 8'h18, 32'h0);
    cmp("unmapped error", 32'h1, e);
    wr(`LBE_OFS_CHECK_OFF, 32'hFFFF_FFFF);
    rd(`LBE_OFS_CHECK_OFF, `LBE_EV_MASK);
    wr(`LBE_OFS_IRQ_ENABLE, 32'hFFFF_FFFF);
    rd(`LBE_OFS_IRQ_ENABLE, `LBE_EV_MASK);
    rd(`LBE_OFS_STATUS, 32'h0);
    wr(`LBE_OFS_CHECK_OFF, 32'h0);
    wr(`LBE_OFS_IRQ_ENABLE, 32'h0);
    wr(`LBE_OFS_ADDR, 32'hFFFF_FFFF);
    rd(`LBE_OFS_ADDR, 32'h0);
    wr(`LBE_OFS_STATUS, 32'hFFFF_FFFF);
    rd(`LBE_OFS_STATUS, 32'h0);
  endtask

  task automatic t_ecc;
    ev(2);
    rd(`LBE_OFS_STATUS, 32'h4);
    rd(`LBE_OFS_ATTR, 32'h8042_A808);
    ev(1);
    rd(`LBE_OFS_STATUS, 32'h4);
    rd(`LBE_OFS_ATTR, 32'h8042_A808);
    wr(`LBE_OFS_STATUS, 32'hFFFF_FFFB);
    rd(`LBE_OFS_STATUS, 32'h4);
    wr(`LBE_OFS_STATUS, 32'h4);
    rd(`LBE_OFS_STATUS, 32'h0);
    wr(`LBE_OFS_ATTR, 32'h0);
    apb(1'h0, `LBE_OFS_ATTR, 32'h0);
    cmp("capture valid", 32'h0, q[31]);
    large_page <= 1'h0;
    ecc_block <= 2'h2;
    ev(2);
    apb(1'h0, `LBE_OFS_ATTR, 32'h0);
    cmp("upper block flags", 32'h0, q[19:17]);
    clr();
  endtask

  task automatic t_events;
    int        ks[3] = '{0, 1, 3};
    lbe_word_t bs[3] = '{32'h20, 32'h1000, 32'h8000_0000};
    txn_write <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      txn_src_valid <= (i != 1);
      ev(ks[i]);
      rd(`LBE_OFS_STATUS, bs[i]);
      apb(1'h0, `LBE_OFS_ATTR, 32'h0);
      cmp("direction", 32'h0, q[3]);
      cmp("capture valid", 32'h1, q[31]);
      cmp("initiator code", (i == 1) ? 32'h0 : 32'h15, q[15:11]);
      if (i == 0) rd(`LBE_OFS_ADDR, 32'hA5C3_1E70);
      clr();
    end
  endtask

  task automatic t_irq;
    wr(`LBE_OFS_STATUS, 32'hFFFF_FFFF);
    wr(`LBE_OFS_IRQ_ENABLE, 32'h20);
    ev(1);
    repeat (2) @(negedge pclk);
    cmp("irq masked", 32'h0, irq);
    clr();
    wr(`LBE_OFS_IRQ_ENABLE, 32'h1000);
    ev(1);
    repeat (2) @(negedge pclk);
    cmp("irq raised", 32'h1, irq);
    wr(`LBE_OFS_STATUS, 32'h1000);
    repeat (2) @(negedge pclk);
    cmp("irq cleared", 32'h0, irq);
    wr(`LBE_OFS_ATTR, 32'h0);
  endtask

  task automatic t_off;
    wr(`LBE_OFS_CHECK_OFF, 32'h1000);
    ev(1);
    rd(`LBE_OFS_STATUS, 32'h0);
    cmp("irq with check off", 32'h0, irq);
    wr(`LBE_OFS_CHECK_OFF, 32'h3);
    wr(`LBE_OFS_CONFIG, 32'h0000_0500);
    tmo(4, 39, 42);
    tmo(5, 255, 258);
    rd(`LBE_OFS_STATUS, 32'h0);
    wr(`LBE_OFS_CHECK_OFF, 32'h0);
    wr(`LBE_OFS_IRQ_ENABLE, 32'h0);
  endtask

  task automatic t_timers;
    tmo(4, 39, 42);
    rd(`LBE_OFS_STATUS, 32'h1);
    clr();
    tmo(5, 255, 258);
    rd(`LBE_OFS_STATUS, 32'h2);
    clr();
    wr(`LBE_OFS_CONFIG, 32'h0000_0301);
    tmo(4, 47, 50);
    clr();
    wr(`LBE_OFS_CONFIG, 32'h0);
    tmo(4, 2047, 2050);
    clr();
    wr(`LBE_OFS_CONFIG, 32'h0000_0500);
    ev(4);
    ev(6);
    ev(5);
    ev(7);
    repeat (300) @(posedge pclk);
    rd(`LBE_OFS_STATUS, 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_ecc();
    t_events();
    t_irq();
    t_off();
    t_timers();
    results();
  end

  // the longest wait is the 2048-cycle monitor period, well inside this
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
endmodule // lbe_error_report_tb
